// ### fsp_pkg.sv
// shared constants and types for the flash self-programming section control
package fsp_pkg;
    localparam int unsigned ADDR_W           = 13;            // word address, 8k words
    localparam logic [12:0] HALT_BASE        = 13'h1c00;      // fixed concurrent/halting split
    localparam logic [12:0] BOOT_BASE_SZ0    = 13'h1c00;      // boot size fuses = 2'b00
    localparam logic [12:0] BOOT_BASE_SZ1    = 13'h1e00;
    localparam logic [12:0] BOOT_BASE_SZ2    = 13'h1f00;
    localparam logic [12:0] BOOT_BASE_SZ3    = 13'h1f80;
    localparam int unsigned PROG_TIME_US     = 4000;          // page erase/write time, plain default
    localparam int unsigned CLK_MHZ          = 20;
    localparam int unsigned PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
    localparam logic [2:0]  OFS_CTRL         = 3'h0;          // control / status
    localparam logic [2:0]  OFS_IRQ_STAT     = 3'h1;
    localparam logic [2:0]  OFS_IRQ_MASK     = 3'h2;
    localparam logic [2:0]  OFS_ADDR_LO      = 3'h3;          // last target, low byte
    localparam logic [2:0]  OFS_ADDR_HI      = 3'h4;
    localparam int unsigned CTRL_BUSY_BIT    = 6;
    localparam int unsigned CTRL_CLR_BIT     = 4;
    localparam int unsigned CTRL_RUN_BIT     = 0;
    localparam int unsigned IRQ_DONE_BIT     = 0;
    localparam int unsigned IRQ_REFUSE_BIT   = 1;
    localparam logic [1:0]  IRQ_RESET        = 2'h0;
    localparam logic [7:0]  RDATA_RESET      = 8'h00;

    typedef enum logic [1:0] {
        FSP_OP_ERASE,
        FSP_OP_WRITE,
        FSP_OP_LOAD,
        FSP_OP_NONE
    } fsp_op_type;

    typedef struct packed {
        logic       valid;
        fsp_op_type op;
        logic [12:0] z_addr;
        logic [12:0] pc;
    } fsp_req_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fsp_bus_type;
endpackage : fsp_pkg

// ### fsp_section_decode.sv
// address-to-section decode for boot/application and halting/concurrent split
`timescale 1ns/1ps
`default_nettype none
module fsp_section_decode (
    input  wire logic [12:0] addr,          // word address
    input  wire logic [1:0]  boot_size,     // boot size fuses
    output logic             in_boot,       // address inside boot section
    output logic             in_halting     // address inside halting section
);
    import fsp_pkg::*;

    function automatic logic [12:0] boot_base(input logic [1:0] sz);
        case (sz)
            2'h0:    boot_base = BOOT_BASE_SZ0;
            2'h1:    boot_base = BOOT_BASE_SZ1;
            2'h2:    boot_base = BOOT_BASE_SZ2;
            default: boot_base = BOOT_BASE_SZ3;
        endcase
    endfunction

    // every boot base sits at or above the halting base, so boot is always halting
    assign in_boot    = (addr >= boot_base(boot_size)); // [RULE4] [RULE12]
    assign in_halting = (addr >= HALT_BASE);            // [RULE6]
endmodule // fsp_section_decode
`default_nettype wire

// ### fsp_prog_timer.sv
// programming duration counter
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_timer #(
    parameter int unsigned CYCLES = fsp_pkg::PROG_CYCLES    // erase/write length
) (
    input  wire logic clock,     // core clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic start,     // one-cycle start pulse
    output logic      running,   // operation in progress
    output logic      done       // one-cycle end pulse
);
    import fsp_pkg::*;
    logic [31:0] count_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 32'h0;
            running   <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !running) begin
                count_reg <= CYCLES[31:0];
                running   <= 1'b1;
            end else if (running) begin
                if (count_reg <= 32'h1) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                count_reg <= count_reg - 32'h1;
            end
        end
    end
endmodule // fsp_prog_timer
`default_nettype wire

// ### fsp_sequencer.sv
// section and access control for flash self-programming
// Operation
// [RULE1] program store only from boot section
// [RULE2] permitted store may target any page
// [RULE3] boot code may rewrite boot section
// [RULE4] fuses set boot/application split
// [RULE5] separate lock bits per section
// [RULE6] fixed concurrent/halting split by address
// [RULE7] stall decision from z pointer target
// [RULE8] concurrent target: core runs, halting readable
// [RULE9] halting target: core stalled throughout
// [RULE10] concurrent section unreadable while programming
// [RULE11] software avoids concurrent section while programming
// [RULE12] boot section always inside halting section
// [RULE13] busy flag high while concurrent blocked
// [RULE14] software clears busy before concurrent reads
// [RULE15] erase/write to concurrent sets busy
// [RULE16] busy clears by strobe or load
// [RULE17] application store is a no-operation
`timescale 1ns/1ps
`default_nettype none
module fsp_sequencer #(
    parameter int unsigned PROG_CYCLES_P = fsp_pkg::PROG_CYCLES  // shorten for simulation
) (
    input  wire logic                 clock,         // core clock, 20 MHz
    input  wire logic                 rst_b,         // async reset, active low
    input  wire fsp_pkg::fsp_req_type req,           // store-program request from core
    input  wire logic [1:0]           boot_size_fuses, // boot size fuses
    input  wire logic [1:0]           app_lock,      // application lock bits, 0 = programmed
    input  wire logic [1:0]           boot_lock,     // boot lock bits, 0 = programmed
    input  wire logic [12:0]          fetch_addr,    // core fetch/read address
    input  wire fsp_pkg::fsp_bus_type bus,           // register port
    output logic [7:0]                rdata,         // read data, cycle after read
    output logic                      core_stall,    // hold core pipeline
    output logic                      read_block,    // previous cycle's fetch address blocked
    output logic                      flash_erase,   // erase strobe to array
    output logic                      flash_write,   // write strobe to array
    output logic                      flash_load,    // page buffer load strobe
    output logic [12:0]               flash_addr,    // page target
    output logic                      irq            // level interrupt
);
    import fsp_pkg::*;

    logic        z_boot, z_halt, pc_boot, f_halt;
    logic        run_en_reg;
    logic        busy_reg;
    logic        halt_op_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic [12:0] last_addr_reg;
    logic        tmr_running, tmr_done;
    logic        prog_req, allowed, locked, start_prog, refused, clr_wr;

    fsp_section_decode u_dec_z (
        .addr       (req.z_addr),
        .boot_size  (boot_size_fuses),
        .in_boot    (z_boot),
        .in_halting (z_halt)
    );
    fsp_section_decode u_dec_pc (
        .addr       (req.pc),
        .boot_size  (boot_size_fuses),
        .in_boot    (pc_boot),
        .in_halting ()
    );
    fsp_section_decode u_dec_f (
        .addr       (fetch_addr),
        .boot_size  (boot_size_fuses),
        .in_boot    (),
        .in_halting (f_halt)
    );

    fsp_prog_timer #(.CYCLES(PROG_CYCLES_P)) u_tmr (
        .clock   (clock),
        .rst_b   (rst_b),
        .start   (start_prog),
        .running (tmr_running),
        .done    (tmr_done)
    );

    // mode 2 and 3 both have bit 0 programmed: writes barred to that section
    assign locked     = z_boot ? !boot_lock[0] : !app_lock[0];            // [RULE5]
    assign prog_req   = req.valid && (req.op == FSP_OP_ERASE || req.op == FSP_OP_WRITE);
    // any page, boot included, provided the caller runs from boot
    assign allowed    = pc_boot && run_en_reg && !locked && !tmr_running; // [RULE1] [RULE2] [RULE3]
    assign start_prog = prog_req && allowed;
    assign refused    = prog_req && !allowed;                             // [RULE17]
    assign clr_wr     = bus.wr && bus.addr == OFS_CTRL && bus.wdata[CTRL_CLR_BIT];

    // array strobes and target
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flash_erase   <= 1'b0;
            flash_write   <= 1'b0;
            flash_load    <= 1'b0;
            flash_addr    <= 13'h0;
            last_addr_reg <= 13'h0;
        end else begin
            flash_erase <= start_prog && req.op == FSP_OP_ERASE;
            flash_write <= start_prog && req.op == FSP_OP_WRITE;
            flash_load  <= req.valid && req.op == FSP_OP_LOAD && pc_boot && !tmr_running;
            if (start_prog) begin
                flash_addr    <= req.z_addr;
                last_addr_reg <= req.z_addr;
            end
        end
    end

    // which split the running operation targets
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            halt_op_reg <= 1'b0;
        end else if (start_prog) begin
            halt_op_reg <= z_halt;                                         // [RULE7]
        end
    end

    // busy flag: set by concurrent-section op, cleared by strobe after done or load
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (start_prog && !z_halt) begin
            busy_reg <= 1'b1;                                              // [RULE15]
        end else if (req.valid && req.op == FSP_OP_LOAD && pc_boot && !tmr_running) begin
            busy_reg <= 1'b0;                                              // [RULE16]
        end else if (clr_wr && !tmr_running) begin
            busy_reg <= 1'b0;                                              // [RULE16] [RULE14]
        end
    end

    // stall and read blocking; registered, so they lag the target by one cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            core_stall <= 1'b0;
            read_block <= 1'b0;
        end else begin
            // a halting-section op stalls from start until the timer ends
            core_stall <= (start_prog && z_halt) ||
                          (tmr_running && halt_op_reg && !tmr_done);      // [RULE9] [RULE8]
            // concurrent section closed while busy; halting stays open
            read_block <= (busy_reg || (start_prog && !z_halt)) && !f_halt; // [RULE10] [RULE13] [RULE11]
        end
    end

    // control enable, interrupt status and mask
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_en_reg   <= 1'b0;
            irq_mask_reg <= IRQ_RESET;
        end else if (bus.wr) begin
            if (bus.addr == OFS_CTRL)
                run_en_reg <= bus.wdata[CTRL_RUN_BIT];
            if (bus.addr == OFS_IRQ_MASK)
                irq_mask_reg <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_reg <= IRQ_RESET;
        end else begin
            // set wins over a write-one clear in the same cycle
            irq_stat_reg[IRQ_DONE_BIT] <= tmr_done ||
                (irq_stat_reg[IRQ_DONE_BIT] &&
                 !(bus.wr && bus.addr == OFS_IRQ_STAT && bus.wdata[IRQ_DONE_BIT]));
            irq_stat_reg[IRQ_REFUSE_BIT] <= refused ||
                (irq_stat_reg[IRQ_REFUSE_BIT] &&
                 !(bus.wr && bus.addr == OFS_IRQ_STAT && bus.wdata[IRQ_REFUSE_BIT]));
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

    // read port; data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= RDATA_RESET;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_CTRL:     rdata <= {1'b0, busy_reg, 5'h0, run_en_reg}; // [RULE13]
                OFS_IRQ_STAT: rdata <= {6'h0, irq_stat_reg};
                OFS_IRQ_MASK: rdata <= {6'h0, irq_mask_reg};
                OFS_ADDR_LO:  rdata <= last_addr_reg[7:0];
                OFS_ADDR_HI:  rdata <= {3'h0, last_addr_reg[12:8]};
                default:      rdata <= RDATA_RESET;
            endcase
        end else begin
            rdata <= RDATA_RESET;
        end
    end
endmodule // fsp_sequencer
`default_nettype wire

// ### fsp_props.sv
// assertion checker for the flash self-programming section control
`timescale 1ns/1ps
`default_nettype none
module fsp_props
    import fsp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = 10  // operation length
) (
    input wire logic                 clock,       // core clock
    input wire logic                 rst_b,       // async reset, active low
    input wire fsp_pkg::fsp_req_type req,         // core request
    input wire logic [1:0]           app_lock,    // application lock bits
    input wire logic [12:0]          fetch_addr,  // core read address
    input wire fsp_pkg::fsp_bus_type bus,         // register port
    input wire logic [7:0]           rdata,       // read data
    input wire logic                 core_stall,  // core hold
    input wire logic                 read_block,  // fetch blocked
    input wire logic                 flash_erase, // erase strobe
    input wire logic                 flash_write, // write strobe
    input wire logic                 flash_load,  // load strobe
    input wire logic [12:0]          flash_addr   // page target
);
    int unsigned stall_cnt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // counts a stall run so a stuck stall is caught without long repetition
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b) stall_cnt <= 0;
        else stall_cnt <= core_stall ? stall_cnt + 1 : 0;
    app_store_a: assert property (req.valid && req.op != FSP_OP_LOAD && req.pc < HALT_BASE
        |=> !(flash_erase || flash_write)) else $error("store from application started");
    lock_bar_a: assert property (req.valid && req.op == FSP_OP_ERASE && !app_lock[0]
        && req.z_addr < HALT_BASE |=> !flash_erase) else $error("locked erase started");
    strobe_cause_a: assert property (flash_erase |-> $past(req.valid)
        && flash_addr == $past(req.z_addr)) else $error("erase without matching request");
    halt_stall_a: assert property ((flash_erase || flash_write) && flash_addr >= HALT_BASE
        |-> core_stall [*8]) else $error("halting target did not stall");
    run_free_a: assert property ((flash_erase || flash_write) && flash_addr < HALT_BASE
        |-> !core_stall) else $error("concurrent target stalled core");
    busy_block_a: assert property ((flash_erase || flash_write) && flash_addr < HALT_BASE
        && fetch_addr < HALT_BASE |=> read_block) else $error("concurrent read not blocked");
    block_addr_a: assert property (read_block |-> $past(fetch_addr) < HALT_BASE)
        else $error("halting read blocked");
    load_clear_a: assert property (flash_load |=> !read_block)
        else $error("load left busy set");
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    stall_len_a: assert property (stall_cnt <= PROG_CYCLES_P + 2)
        else $error("stall too long");
endmodule // fsp_props
bind fsp_sequencer fsp_props #(.PROG_CYCLES_P(PROG_CYCLES_P)) i_props (.*);
`default_nettype wire

// ### fsp_core_model.sv
// behavioural core issuing program-store requests and fetches
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
    input  wire logic                clock,      // core clock
    output var fsp_pkg::fsp_req_type req,        // request to sequencer
    output var logic [12:0]          fetch_addr  // fetch address
);
    import fsp_pkg::*;
    initial begin
        req = '0;
        fetch_addr = HALT_BASE;
    end
    task automatic issue(input fsp_op_type op, input logic [12:0] z, input logic [12:0] pc);
        req <= '{1'b1, op, z, pc};
        fetch_addr <= pc;
        @(posedge clock);
        req <= '0;
        #1;
    endtask
    task automatic fetch(input logic [12:0] a);
        fetch_addr <= a;
    endtask
endmodule // fsp_core_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the flash self-programming section control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fsp_pkg::*;
    localparam int unsigned P = 10;
    localparam logic [12:0] BASES [4] = '{BOOT_BASE_SZ0, BOOT_BASE_SZ1, BOOT_BASE_SZ2, BOOT_BASE_SZ3};
    logic        clock = 0, rst_b = 0, core_stall, read_block, flash_erase, flash_write;
    logic        flash_load, irq;
    logic [1:0]  fuses = 2'h3, app_lock = 2'h3, boot_lock = 2'h3;
    logic [12:0] fetch_addr, flash_addr;
    logic [7:0]  rdata;
    fsp_req_type req;
    fsp_bus_type bus = '0;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    fsp_core_model i_core (.clock(clock), .req(req), .fetch_addr(fetch_addr));
    fsp_sequencer #(.PROG_CYCLES_P(P)) i_dut (.clock(clock), .rst_b(rst_b), .req(req),
        .boot_size_fuses(fuses), .app_lock(app_lock), .boot_lock(boot_lock),
        .fetch_addr(fetch_addr), .bus(bus), .rdata(rdata), .core_stall(core_stall),
        .read_block(read_block), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_load(flash_load), .flash_addr(flash_addr), .irq(irq));
    initial forever #25 clock = ~clock;
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // each cycle task returns 1 ns past an edge so no driver hits one step twice
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        #1 chk(n, rdata, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic t_app();
        i_core.issue(FSP_OP_ERASE, 13'h0100, 13'h0100);
        chk("app erase", flash_erase, 1'b0);
        idle(1);
        chk("app stall", core_stall, 1'b0);
        rd(OFS_IRQ_STAT, 8'h02, "refused flag");
        chk("irq raised", irq, 1'b1);
        wr(OFS_IRQ_MASK, 8'h01);
        idle(1);
        chk("irq masked", irq, 1'b0);
        wr(OFS_IRQ_STAT, 8'h02);
        wr(OFS_IRQ_MASK, 8'h03);
        idle(1);
        chk("irq cleared", irq, 1'b0);
        rd(OFS_CTRL, 8'h01, "app busy");
        $display("t_app done");
    endtask
    task automatic t_rww();
        i_core.issue(FSP_OP_WRITE, 13'h0123, BOOT_BASE_SZ3);
        chk("rww strobe", flash_write, 1'b1);
        chk("rww addr", flash_addr, 13'h0123);
        chk("rww stall", core_stall, 1'b0);
        i_core.fetch(13'h0100);
        idle(2);
        chk("rww block", read_block, 1'b1);
        i_core.fetch(HALT_BASE);
        idle(2);
        chk("halt read", read_block, 1'b0);
        wr(OFS_CTRL, 8'h11);
        rd(OFS_CTRL, 8'h41, "clear while running");
        idle(P);
        rd(OFS_CTRL, 8'h41, "busy held");
        wr(OFS_CTRL, 8'h11);
        rd(OFS_CTRL, 8'h01, "busy strobe");
        rd(OFS_IRQ_STAT, 8'h01, "done flag");
        wr(OFS_IRQ_STAT, 8'h01);
        rd(OFS_ADDR_LO, 8'h23, "target low");
        rd(OFS_ADDR_HI, 8'h01, "target high");
        $display("t_rww done");
    endtask
    task automatic t_halting_section();
        i_core.issue(FSP_OP_ERASE, BOOT_BASE_SZ3, BOOT_BASE_SZ3);
        chk("boot erase", flash_erase, 1'b1);
        chk("halt stall", core_stall, 1'b1);
        idle(P - 2);
        chk("stall held", core_stall, 1'b1);
        idle(5);
        chk("stall end", core_stall, 1'b0);
        rd(OFS_CTRL, 8'h01, "boot no busy");
        $display("t_halting_section done");
    endtask
    task automatic t_load();
        i_core.issue(FSP_OP_ERASE, 13'h0200, BOOT_BASE_SZ3);
        idle(P + 3);
        rd(OFS_CTRL, 8'h41, "load busy set");
        i_core.issue(FSP_OP_LOAD, 13'h0200, BOOT_BASE_SZ3);
        chk("load strobe", flash_load, 1'b1);
        rd(OFS_CTRL, 8'h01, "load clears");
        i_core.fetch(13'h0200);
        idle(2);
        chk("load open", read_block, 1'b0);
        $display("t_load done");
    endtask
    task automatic t_lock();
        app_lock <= 2'h2;
        i_core.issue(FSP_OP_ERASE, 13'h0100, BOOT_BASE_SZ3);
        chk("app locked", flash_erase, 1'b0);
        i_core.issue(FSP_OP_ERASE, BOOT_BASE_SZ3, BOOT_BASE_SZ3);
        chk("boot free", flash_erase, 1'b1);
        idle(P + 3);
        app_lock <= 2'h3;
        boot_lock <= 2'h2;
        i_core.issue(FSP_OP_WRITE, BOOT_BASE_SZ3, BOOT_BASE_SZ3);
        chk("boot locked", flash_write, 1'b0);
        boot_lock <= 2'h3;
        $display("t_lock done");
    endtask
    task automatic t_fuse();
        for (int i = 0; i < 4; i++) begin
            fuses <= i[1:0];
            i_core.issue(FSP_OP_ERASE, 13'h1f80, BASES[i] - 13'h0001);
            chk("below base", flash_erase, 1'b0);
            i_core.issue(FSP_OP_ERASE, 13'h1f80, BASES[i]);
            chk("at base", flash_erase, 1'b1);
            idle(P + 3);
        end
        $display("t_fuse done");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        idle(1);
        rd(OFS_CTRL, 8'h00, "ctrl reset");
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00, "unmapped");
        wr(OFS_CTRL, 8'h01);
        wr(OFS_IRQ_MASK, 8'h03);
        t_app();
        t_rww();
        t_halting_section();
        t_load();
        t_lock();
        t_fuse();
        final_report();
    end
endmodule // tb
`default_nettype wire
